// File: src/uptr_pkg.sv
// Constants, types and register map of the USB port tuning register bank.
package uptr_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] IDX_P4_BOOST   = 16'h70CA;
  localparam logic [15:0] IDX_P4_SQUELCH = 16'h70CC;
  localparam logic [15:0] IDX_P4_STATUS  = 16'h71C0;
  localparam logic [15:0] IDX_P5_BOOST   = 16'h74CA;
  localparam logic [15:0] IDX_P5_SQUELCH = 16'h74CC;
  localparam logic [15:0] IDX_P6_BOOST   = 16'h78CA;
  localparam logic [15:0] IDX_P6_SQUELCH = 16'h78CC;
  localparam logic [15:0] IDX_P7_BOOST   = 16'h7CCA;
  localparam logic [15:0] IDX_P7_SQUELCH = 16'h7CCC;

  // ****************************************************************
  // Field layout and reset values.
  // ****************************************************************
  localparam int unsigned NUM_PORTS  = 4;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned CODE_W     = 3;
  localparam int unsigned STATE_W    = 4;
  localparam int unsigned SUB_W      = 3;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;
  localparam logic [7:0]  BOOST_RST  = 8'h00;
  localparam logic [2:0]  CODE_RST   = 3'h0;
  localparam logic [0:0]  STAT_RSVD  = 1'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Drive current and squelch code meanings.
  // ****************************************************************
  typedef enum logic [2:0] {
    DRV_NOMINAL = 3'h0,
    DRV_MINUS5  = 3'h1,
    DRV_PLUS10  = 3'h2,
    DRV_PLUS5   = 3'h3,
    DRV_PLUS20  = 3'h4,
    DRV_PLUS15  = 3'h5,
    DRV_PLUS30  = 3'h6,
    DRV_PLUS25  = 3'h7
  } uptr_drive_t;

  typedef enum logic [2:0] {
    SQ_NOMINAL  = 3'h0,
    SQ_MINUS125 = 3'h1,
    SQ_MINUS250 = 3'h2,
    SQ_MINUS375 = 3'h3,
    SQ_MINUS500 = 3'h4,
    SQ_MINUS625 = 3'h5,
    SQ_PLUS250  = 3'h6,
    SQ_PLUS125  = 3'h7
  } uptr_squelch_t;

  // Link state codes; codes above loopback are not defined.
  typedef enum logic [3:0] {
    LS_U0         = 4'h0,
    LS_U1         = 4'h1,
    LS_U2         = 4'h2,
    LS_U3         = 4'h3,
    LS_DISABLED   = 4'h4,
    LS_RX_DETECT  = 4'h5,
    LS_INACTIVE   = 4'h6,
    LS_POLLING    = 4'h7,
    LS_RECOVERY   = 4'h8,
    LS_HOT_RESET  = 4'h9,
    LS_COMPLIANCE = 4'hA,
    LS_LOOPBACK   = 4'hB
  } uptr_link_state_t;

  // Codes carried to one port's transceiver.
  typedef struct packed {
    uptr_drive_t   drive_current_code;
    uptr_squelch_t squelch_threshold_code;
  } uptr_tune_t;

  // Link status as sampled from the SuperSpeed port.
  typedef struct packed {
    uptr_link_state_t state;
    logic [2:0]       sub_state;
  } uptr_link_t;

endpackage : uptr_pkg

// File: src/uptr_sync.sv
// Two-flop synchroniser for a group of level signals.
`timescale 1ns/100ps
module uptr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule : uptr_sync

// File: src/uptr_port_cell.sv
// Boost and squelch registers of one high-speed port.
`timescale 1ns/100ps
module uptr_port_cell (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               wr_boost_i,
  input  wire logic               wr_squelch_i,
  input  wire logic [7:0]         wdata_i,
  output logic      [7:0]         boost_reg_o,
  output uptr_pkg::uptr_tune_t    tune_o
);

  logic [7:0]           next_boost;
  uptr_pkg::uptr_tune_t next_tune;

  always_comb begin
    next_boost = boost_reg_o;
    next_tune  = tune_o;
    if (wr_boost_i) begin
      // Upper bits are stored and read back but steer nothing.
      next_boost = wdata_i;
      next_tune.drive_current_code =
        uptr_pkg::uptr_drive_t'(wdata_i[uptr_pkg::CODE_W-1:0]);
    end
    if (wr_squelch_i) begin
      next_tune.squelch_threshold_code =
        uptr_pkg::uptr_squelch_t'(wdata_i[uptr_pkg::CODE_W-1:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boost_reg_o <= uptr_pkg::BOOST_RST;
      tune_o      <= '{drive_current_code: uptr_pkg::DRV_NOMINAL,
                       squelch_threshold_code: uptr_pkg::SQ_NOMINAL};
    end else begin
      boost_reg_o <= next_boost;
      tune_o      <= next_tune;
    end
  end

endmodule : uptr_port_cell

// File: src/uptr_regs.sv
// Avalon-MM register bank for the tuning registers of ports 4 to 7 and the status register of port 4.
`timescale 1ns/100ps
module uptr_regs (
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  // Avalon-MM slave, word addressed by register index.
  input  wire logic [15:0]                avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  // Port 4 SuperSpeed link status from the link layer.
  input  wire logic [3:0]                 link_state_i,
  input  wire logic [2:0]                 link_sub_state_i,
  // Tuning codes to the transceivers, index 0 is port 4.
  output uptr_pkg::uptr_tune_t [3:0]      port_tune_o
);

  // ****************************************************************
  // Reset release.
  // ****************************************************************

  logic rst_meta;
  logic rst_n;

  // Assertion is immediate; release waits two clock edges.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // Link status sampling.
  // ****************************************************************

  // The link status comes from another clock. The code is sampled
  // bit by bit, so a read taken while the state changes may return a
  // mixed code for one cycle; software should read twice if it cares.
  logic [6:0]           link_raw;
  logic [6:0]           link_sync;
  uptr_pkg::uptr_link_t link_now;

  assign link_raw = {link_state_i, link_sub_state_i};

  uptr_sync #(
    .WIDTH (7)
  ) u_link_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (link_raw),
    .q_o     (link_sync)
  );

  always_comb begin
    link_now.state     = uptr_pkg::uptr_link_state_t'(
                           link_sync[6:uptr_pkg::SUB_W]);
    link_now.sub_state = link_sync[uptr_pkg::SUB_W-1:0];
  end

  // ****************************************************************
  // Bus handshake.
  // ****************************************************************

  // Every access takes one wait state: the first cycle of a request
  // latches the answer, the second completes it. This keeps read data
  // registered at the cost of one cycle per access.
  logic ack;
  logic next_ack;
  logic req;
  logic done;

  assign req  = avs_read_i | avs_write_i;
  assign done = req & ack;

  always_comb begin
    next_ack = req & ~ack;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  assign avs_waitrequest_o = req & ~ack;

  // ****************************************************************
  // Address decode.
  // ****************************************************************

  logic [3:0] hit_boost;
  logic [3:0] hit_squelch;
  logic       hit_status;

  always_comb begin
    hit_boost[0]   = avs_address_i == uptr_pkg::IDX_P4_BOOST;
    hit_boost[1]   = avs_address_i == uptr_pkg::IDX_P5_BOOST;
    hit_boost[2]   = avs_address_i == uptr_pkg::IDX_P6_BOOST;
    hit_boost[3]   = avs_address_i == uptr_pkg::IDX_P7_BOOST;
    hit_squelch[0] = avs_address_i == uptr_pkg::IDX_P4_SQUELCH;
    hit_squelch[1] = avs_address_i == uptr_pkg::IDX_P5_SQUELCH;
    hit_squelch[2] = avs_address_i == uptr_pkg::IDX_P6_SQUELCH;
    hit_squelch[3] = avs_address_i == uptr_pkg::IDX_P7_SQUELCH;
    hit_status     = avs_address_i == uptr_pkg::IDX_P4_STATUS;
  end

  // ****************************************************************
  // Write strobes.
  // ****************************************************************

  // Registers sit in byte lane 0; a write without that lane changes
  // nothing. Writes to unmapped indices are completed and dropped.
  logic       wr_lane0;
  logic [3:0] wr_boost;
  logic [3:0] wr_squelch;

  assign wr_lane0   = done & avs_write_i & avs_byteenable_i[0];
  assign wr_boost   = hit_boost & {4{wr_lane0}};
  assign wr_squelch = hit_squelch & {4{wr_lane0}};

  // ****************************************************************
  // Port registers.
  // ****************************************************************

  logic [3:0][7:0] boost_reg;

  // One cell per port keeps every port's settings apart.
  genvar gi;
  generate
    for (gi = 0; gi < uptr_pkg::NUM_PORTS; gi++) begin : g_port
      uptr_port_cell u_cell (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n),
        .wr_boost_i   (wr_boost[gi]),
        .wr_squelch_i (wr_squelch[gi]),
        .wdata_i      (avs_writedata_i[uptr_pkg::REG_W-1:0]),
        .boost_reg_o  (boost_reg[gi]),
        .tune_o       (port_tune_o[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read data.
  // ****************************************************************

  logic [7:0]  rd_byte;
  logic [31:0] next_rdata;

  always_comb begin
    rd_byte = '0;
    for (int i = 0; i < uptr_pkg::NUM_PORTS; i++) begin
      if (hit_boost[i]) begin
        rd_byte = boost_reg[i];
      end
      if (hit_squelch[i]) begin
        rd_byte = {5'h00,
                   port_tune_o[i].squelch_threshold_code};
      end
    end
    if (hit_status) begin
      rd_byte = {link_now.state,
                 uptr_pkg::STAT_RSVD,
                 link_now.sub_state};
    end
    next_rdata = avs_readdata_o;
    if (avs_read_i & ~ack) begin
      next_rdata = {24'h000000, rd_byte};
    end
  end

  // Read data is held until the next read is latched.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= uptr_pkg::RDATA_ZERO;
    end else begin
      avs_readdata_o <= next_rdata;
    end
  end

endmodule : uptr_regs

// File: verif/uptr_regs_properties.sv
// Port checker of the tuning register bank.
`timescale 1ns/100ps
module uptr_regs_properties (
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  input  wire logic [15:0]                avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  input  wire logic [31:0]                avs_readdata_o,
  input  wire logic                       avs_waitrequest_o,
  input  wire logic [3:0]                 link_state_i,
  input  wire logic [2:0]                 link_sub_state_i,
  input  wire uptr_pkg::uptr_tune_t [3:0] port_tune_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************************************
  // Completed transfers.
  // ****************************************************************
  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  sequence s_wr_done;
    avs_write_i && !avs_waitrequest_o;
  endsequence
  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait state on a new request");
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest while idle");
  a_rdata_upper: assert property (s_rd_done |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_squelch_rsvd: assert property (s_rd_done ##0 avs_address_i[7:0] == 8'hCC |-> avs_readdata_o[7:3] == 5'h00)
    else $error("squelch reserved bits not zero");
  a_status_rsvd: assert property (s_rd_done ##0 avs_address_i == uptr_pkg::IDX_P4_STATUS |-> !avs_readdata_o[3])
    else $error("status bit 3 not zero");
  a_tune_hold: assert property (!$past(avs_write_i && !avs_waitrequest_o) |-> $stable(port_tune_o))
    else $error("tuning codes changed without a write");
  a_drive_follow: assert property (s_wr_done ##0 avs_address_i == uptr_pkg::IDX_P4_BOOST
    && avs_byteenable_i[0] |=> port_tune_o[0].drive_current_code == $past(avs_writedata_i[2:0]))
    else $error("drive code not applied");
  a_squelch_follow: assert property (s_wr_done ##0 avs_address_i == uptr_pkg::IDX_P7_SQUELCH
    && avs_byteenable_i[0] |=> port_tune_o[3].squelch_threshold_code == $past(avs_writedata_i[2:0]))
    else $error("squelch code not applied");
  a_unmapped_zero: assert property (s_rd_done ##0 avs_address_i == 16'h70CB |-> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule : uptr_regs_properties

// File: verif/tb_uptr_regs.sv
// Self-checking bench of the tuning register bank.
`timescale 1ns/100ps
module tb_uptr_regs;
  logic                       clk_i = 1'b0;
  logic                       nrst_i = 1'b0;
  logic [15:0]                avs_address_i = 16'h0000;
  logic                       avs_read_i = 1'b0;
  logic                       avs_write_i = 1'b0;
  logic [31:0]                avs_writedata_i = 32'h00000000;
  logic [3:0]                 avs_byteenable_i = 4'h0;
  logic [31:0]                avs_readdata_o;
  logic                       avs_waitrequest_o;
  logic [3:0]                 link_state_i = 4'h0;
  logic [2:0]                 link_sub_state_i = 3'h0;
  uptr_pkg::uptr_tune_t [3:0] port_tune_o;
  int                         err_total = 0;
  int                         n_compared = 0;
  logic [31:0]                q;
  logic [2:0]                 sq = 3'h0;
  logic [15:0]                bidx [4] = '{16'h70CA, 16'h74CA, 16'h78CA, 16'h7CCA};
  logic [15:0]                sidx [4] = '{16'h70CC, 16'h74CC, 16'h78CC, 16'h7CCC};

  always #12.5 clk_i = ~clk_i;

  uptr_regs uptr_regs_inst (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .link_state_i, .link_sub_state_i, .port_tune_o);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Bus access: the request stands until waitrequest is seen low at a rising edge.
  // ****************************************************************
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= idx;
    avs_writedata_i <= {24'hFFFFFF, d};
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      err_total++;
      wrap_up();
    end
    // Values read here are those sampled by this edge, before its updates land.
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  // A write lands at the edge that completes it, so the codes are looked at one edge later.
  task automatic tune(input int p, input logic [2:0] d, input logic [2:0] s);
    @(posedge clk_i);
    check({26'h0, port_tune_o[p]}, {26'h0, d, s});
  endtask : tune

  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int p = 0; p < 4; p++) begin
      bus(1'b0, bidx[p], 8'h00, 4'hF, q);
      check(q, 32'h0);
      bus(1'b0, sidx[p], 8'h00, 4'hF, q);
      check(q, 32'h0);
      tune(p, 3'h0, 3'h0);
    end
    bus(1'b0, uptr_pkg::IDX_P4_STATUS, 8'h00, 4'hF, q);
    check(q, 32'h0);
    $display("Test reset values done");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, bidx[1], {5'h15, 3'(c)}, 4'h1, q);
      tune(1, 3'(c), sq);
      bus(1'b0, bidx[1], 8'h00, 4'h1, q);
      check(q, {24'h0, 5'h15, 3'(c)});
      bus(1'b1, sidx[1], {5'h1F, 3'(c)}, 4'h1, q);
      sq = 3'(c);
      bus(1'b0, sidx[1], 8'h00, 4'h1, q);
      check(q, {29'h0, 3'(c)});
      tune(1, 3'(c), sq);
    end
    $display("Test all codes done");
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, bidx[p], 8'(p + 1), 4'hF, q);
      bus(1'b1, sidx[p], 8'(8'hF4 + p), 4'hF, q);
    end
    bus(1'b1, bidx[2], 8'hFF, 4'hE, q);
    bus(1'b1, 16'h70CB, 8'hFF, 4'hF, q);
    bus(1'b1, uptr_pkg::IDX_P4_STATUS, 8'hFF, 4'hF, q);
    bus(1'b0, 16'h70CB, 8'h00, 4'hF, q);
    check(q, 32'h0);
    for (int p = 0; p < 4; p++) begin
      bus(1'b0, bidx[p], 8'h00, 4'hF, q);
      check(q, 32'(p + 1));
      bus(1'b0, sidx[p], 8'h00, 4'hF, q);
      check(q, 32'(p + 4));
      tune(p, 3'(p + 1), 3'(p + 4));
    end
    $display("Test port independence done");
    for (int s = 0; s < 12; s++) begin
      link_state_i <= 4'(s);
      link_sub_state_i <= 3'(s) ^ 3'h5;
      repeat (4) @(posedge clk_i);
      bus(1'b0, uptr_pkg::IDX_P4_STATUS, 8'h00, 4'hF, q);
      check(q, {24'h0, 4'(s), 1'b0, 3'(s) ^ 3'h5});
    end
    $display("Test link status done");
    wrap_up();
  end
endmodule : tb_uptr_regs

bind uptr_regs uptr_regs_properties uptr_regs_properties_inst (.clk_i, .nrst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .link_state_i,
  .link_sub_state_i, .port_tune_o);
